// ---- hw/ext_bus_ctrl.sv ----
// External memory bus, strobe pins, port alternates and clock gating
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctrl #(
  parameter bit LARGE_PKG = 1'b1 // Package has P4.0 to P4.3 pins
) (
  input wire logic clk_i, // Oscillator clock, 10 MHz
  input wire logic rst_b_i, // Async power-on reset, active low
  input wire logic reset_pin_i, // Reset pin, active high
  input wire logic ext_access_select_i, // Access select pin, high allows on-chip code
  input wire logic req_valid_i, // Core memory request
  input wire logic [1:0] req_kind_i, // Request kind, req_kind_t
  input wire logic [15:0] req_addr_i, // Request address
  input wire logic [7:0] req_wdata_i, // Write data
  input wire logic [7:0] rom_data_i, // On-chip program memory byte
  output logic req_ready_o, // Request accepted when valid
  output logic rsp_valid_o, // Read data or write done pulse
  output logic [7:0] rsp_data_o, // Read data
  output logic rsp_internal_o, // Answer came from on-chip memory
  output logic core_rst_o, // Qualified core reset
  input wire logic port0_weak_pullup_en_i, // Option: port 0 pull-ups
  input wire logic [3:0] high_sink_select_i, // Option: P3.4 to P3.7 high sink
  input wire logic latch_pin_alt_enable_i, // Option: latch pin as P4.5
  input wire logic store_pin_alt_enable_i, // Option: store pin as P4.6
  input wire logic latch_pulse_off_i, // Option: no idle latch pulses
  input wire logic opt_wr_i, // Load the option inputs
  input wire logic [7:0] p0_out_i, // Port 0 latch
  input wire logic [7:0] p1_out_i, // Port 1 latch
  input wire logic [7:0] p2_out_i, // Port 2 latch
  input wire logic [7:0] p3_out_i, // Port 3 latch
  input wire logic p4_bit_wr_i, // Port 4 single bit write
  input wire logic [2:0] p4_bit_sel_i, // Port 4 bit number
  input wire logic p4_bit_val_i, // Port 4 bit value
  input wire logic idle_req_i, // Enter idle mode
  input wire logic power_down_req_i, // Enter power-down mode
  input wire logic wake_i, // Interrupt wake-up
  input wire logic [7:0] p0_i, // Port 0 pins in
  output logic [7:0] p0_o, // Port 0 pins out
  output logic [7:0] p0_oe_o, // Port 0 drive enable
  output logic p0_pullup_o, // Port 0 weak pull-ups on
  input wire logic [7:0] p1_i, // Port 1 pins in
  output logic [7:0] p1_o, // Port 1 pins out
  output logic [7:0] p1_oe_o, // Port 1 drive enable
  output logic [7:0] p2_o, // Port 2 pins out
  output logic [7:0] p2_oe_o, // Port 2 drive enable
  input wire logic [7:0] p3_i, // Port 3 pins in
  output logic [7:0] p3_o, // Port 3 pins out
  output logic [7:0] p3_oe_o, // Port 3 drive enable
  output logic [3:0] p3_high_sink_o, // High sink on P3.4 to P3.7
  input wire logic [3:0] p4_i, // Port 4 pins 0 to 3 in
  output logic [3:0] p4_o, // Port 4 pins 0 to 3 out
  output logic [3:0] p4_oe_o, // Port 4 pins 0 to 3 enable
  input wire logic ale_i, // Latch strobe pin in
  output logic ale_o, // Latch strobe pin out
  output logic ale_oe_o, // Latch strobe pin enable
  input wire logic prog_store_strobe_i, // Store strobe pin in
  output logic prog_store_strobe_b_o, // Store strobe pin out, low active
  output logic prog_store_strobe_oe_o, // Store strobe pin enable
  output logic [6:0] p4_in_o, // Port 4 pin levels, synced
  output logic [7:0] port1_irq_inputs_o, // Port 1 interrupt inputs two to nine
  output logic ext_irq_zero_o, // External interrupt zero input
  output logic ext_irq_one_o, // External interrupt one input
  output logic timer_zero_count_in_o, // Timer zero count input
  output logic timer_one_count_in_o, // Timer one count input
  output logic core_clk_en_o, // Core clock gate enable
  output logic periph_clk_en_o, // Peripheral clock gate enable
  output logic osc_en_o // Crystal oscillator enable
);
  reset_link_if rlink ();
  reset_qualify reset_qualify_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .reset_pin_i(reset_pin_i),
    .link(rlink.qual)
  );

  function automatic logic is_code(input logic [1:0] k);
    return k == ext_bus_pkg::KIND_FETCH || k == ext_bus_pkg::KIND_CODE_READ;
  endfunction

  logic core_rst;
  logic [31:0] sync1_r;
  logic [31:0] sync2_r;
  logic ea_s;
  logic [7:0] p0_s;
  logic [7:0] p1_s;
  logic [7:0] p3_s;
  logic [3:0] p4lo_s;
  logic ale_s;
  logic prog_store_strobe_s;
  logic [7:0] opt_r;
  logic [6:0] p4_r;
  logic idle_r;
  logic pd_r;
  ext_bus_pkg::bus_state_t st_r;
  logic [1:0] ph_r;
  logic [3:0] mcyc_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [1:0] kind_r;
  logic int_hit;
  logic accept;
  logic ale_nxt;
  logic prog_store_strobe_nxt;
  logic [7:0] p0_nxt;
  logic [7:0] p0_oe_nxt;
  logic [7:0] p2_nxt;
  logic [7:0] p2_oe_nxt;
  logic [7:0] p3_nxt;
  logic [7:0] p3_oe_nxt;
  logic bus_nxt;
  logic bus_r;

  assign core_rst = rlink.core_rst;
  assign core_rst_o = core_rst;
  assign rlink.osc_run = !pd_r;

  // Pin synchronisers, second stage only is read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 32'hFFFFFFFF;
      sync2_r <= 32'hFFFFFFFF;
    end else begin
      sync1_r <= {ext_access_select_i, ale_i, prog_store_strobe_i, p4_i, p3_i, p1_i, p0_i, 1'b1};
      sync2_r <= sync1_r;
    end
  end
  assign {ea_s, ale_s, prog_store_strobe_s, p4lo_s, p3_s, p1_s, p0_s} = sync2_r[31:1];

  // Option bits, cleared by either reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_r <= ext_bus_pkg::OPT_RESET;
    end else if (core_rst) begin
      opt_r <= ext_bus_pkg::OPT_RESET; // RULE23
    end else if (opt_wr_i) begin
      opt_r <= {store_pin_alt_enable_i, latch_pin_alt_enable_i, latch_pulse_off_i,
                high_sink_select_i, port0_weak_pullup_en_i};
    end
  end

  // Port 4 latch, written one bit at a time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p4_r <= ext_bus_pkg::P4_RESET;
    end else if (core_rst) begin
      p4_r <= ext_bus_pkg::P4_RESET;
    end else if (p4_bit_wr_i && p4_bit_sel_i != 3'h7) begin
      p4_r[p4_bit_sel_i] <= p4_bit_val_i; // RULE15
    end
  end

  // Power modes; registers simply hold if the clock stops
  always_ff @(posedge clk_i or negedge rst_b_i) begin // RULE20
    if (!rst_b_i) begin
      idle_r <= 1'b0;
      pd_r <= 1'b0;
    end else if (core_rst || wake_i) begin
      idle_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      if (idle_req_i) begin
        idle_r <= 1'b1;
      end
      if (power_down_req_i) begin
        pd_r <= 1'b1;
      end
    end
  end
  assign core_clk_en_o = !idle_r && !pd_r; // RULE18
  assign periph_clk_en_o = !pd_r;
  assign osc_en_o = !pd_r; // RULE19

  // Code below 4K with select high stays on chip; all else goes out
  assign int_hit = ea_s && is_code(req_kind_i)
                   && {1'b0, req_addr_i} < ext_bus_pkg::ONCHIP_ROM_BYTES; // RULE1 RULE3
  assign req_ready_o = st_r == ext_bus_pkg::BS_IDLE && !core_rst && !idle_r && !pd_r;
  assign accept = req_valid_i && req_ready_o;

  // Bus cycle sequencer: address, hold past latch fall, strobe, finish
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ext_bus_pkg::BS_IDLE;
      ph_r <= 2'h0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      kind_r <= 2'h0;
    end else if (core_rst) begin
      st_r <= ext_bus_pkg::BS_IDLE;
      ph_r <= 2'h0;
    end else if (st_r == ext_bus_pkg::BS_IDLE) begin
      ph_r <= 2'h0;
      if (accept && !int_hit) begin
        st_r <= ext_bus_pkg::BS_ADDR; // RULE2
        addr_r <= req_addr_i; // RULE4
        wdata_r <= req_wdata_i;
        kind_r <= req_kind_i;
      end
    end else if (ph_r != ext_bus_pkg::PHASE_LAST) begin
      ph_r <= ph_r + 2'h1;
    end else begin
      ph_r <= 2'h0;
      case (st_r)
        ext_bus_pkg::BS_ADDR: st_r <= ext_bus_pkg::BS_HOLD;
        ext_bus_pkg::BS_HOLD: st_r <= ext_bus_pkg::BS_STROBE;
        ext_bus_pkg::BS_STROBE: st_r <= ext_bus_pkg::BS_FINISH;
        default: st_r <= ext_bus_pkg::BS_IDLE;
      endcase
    end
  end

  // Free machine-cycle counter paces idle latch pulses
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcyc_r <= 4'h0;
    end else if (mcyc_r == ext_bus_pkg::MCYC_LAST) begin
      mcyc_r <= 4'h0;
    end else begin
      mcyc_r <= mcyc_r + 4'h1;
    end
  end

  // Answers: internal next cycle, external once strobe data has passed the synchroniser
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_internal_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (accept && int_hit) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= rom_data_i;
        rsp_internal_o <= 1'b1;
      end else if (st_r == ext_bus_pkg::BS_FINISH && ph_r == ext_bus_pkg::PHASE_LAST) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= kind_r == ext_bus_pkg::KIND_DATA_WR ? wdata_r : p0_s;
        rsp_internal_o <= 1'b0;
      end
    end
  end

  // Next pin levels
  always_comb begin
    bus_nxt = st_r != ext_bus_pkg::BS_IDLE && !core_rst;
    ale_nxt = !opt_r[5] && mcyc_r < ext_bus_pkg::ALE_PULSE_END; // RULE22
    prog_store_strobe_nxt = 1'b1;
    p0_nxt = 8'h00;
    p0_oe_nxt = ~p0_out_i;
    p2_nxt = p2_out_i;
    p2_oe_nxt = ~p2_out_i;
    p3_nxt = 8'h00;
    p3_oe_nxt = ~p3_out_i;
    if (bus_nxt) begin
      ale_nxt = st_r == ext_bus_pkg::BS_ADDR; // RULE7
      p2_nxt = addr_r[15:8]; // RULE9
      p2_oe_nxt = 8'hFF;
      case (st_r)
        ext_bus_pkg::BS_ADDR, ext_bus_pkg::BS_HOLD: begin
          p0_nxt = addr_r[7:0]; // RULE8 RULE24
          p0_oe_nxt = 8'hFF;
        end
        ext_bus_pkg::BS_STROBE: begin
          if (is_code(kind_r)) begin
            prog_store_strobe_nxt = 1'b0; // RULE5
            p0_oe_nxt = 8'h00;
          end else if (kind_r == ext_bus_pkg::KIND_DATA_WR) begin
            p0_nxt = wdata_r; // RULE8
            p0_oe_nxt = 8'hFF;
            p3_oe_nxt[ext_bus_pkg::WR_PIN] = 1'b1; // RULE11
          end else begin
            p0_oe_nxt = 8'h00;
            p3_oe_nxt[ext_bus_pkg::RD_PIN] = 1'b1; // RULE11
          end
        end
        default: begin
          p0_oe_nxt = 8'h00;
        end
      endcase
    end
    if (!bus_nxt) begin
      p3_oe_nxt[ext_bus_pkg::WR_PIN] = !p3_out_i[ext_bus_pkg::WR_PIN];
      p3_oe_nxt[ext_bus_pkg::RD_PIN] = !p3_out_i[ext_bus_pkg::RD_PIN];
    end
  end

  // Registered pin drive
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_r <= 1'b0;
      ale_o <= 1'b0;
      ale_oe_o <= 1'b0;
      prog_store_strobe_b_o <= 1'b1;
      prog_store_strobe_oe_o <= 1'b0;
      p0_o <= 8'h00;
      p0_oe_o <= 8'h00;
      p2_o <= ext_bus_pkg::PORT_RESET;
      p2_oe_o <= 8'h00;
      p3_o <= 8'h00;
      p3_oe_o <= 8'h00;
    end else begin
      bus_r <= bus_nxt;
      ale_o <= opt_r[6] ? p4_r[ext_bus_pkg::LATCH_P4_BIT] : ale_nxt; // RULE14 RULE21
      ale_oe_o <= opt_r[6] ? !p4_r[ext_bus_pkg::LATCH_P4_BIT] : 1'b1;
      prog_store_strobe_b_o <= opt_r[7] ? p4_r[ext_bus_pkg::STORE_P4_BIT] : prog_store_strobe_nxt; // RULE6
      prog_store_strobe_oe_o <= opt_r[7] ? !p4_r[ext_bus_pkg::STORE_P4_BIT] : 1'b1; // RULE14 RULE21
      p0_o <= p0_nxt;
      p0_oe_o <= p0_oe_nxt;
      p2_o <= p2_nxt;
      p2_oe_o <= p2_oe_nxt;
      p3_o <= p3_nxt;
      p3_oe_o <= p3_oe_nxt;
    end
  end

  assign p0_pullup_o = opt_r[0]; // RULE16
  assign p3_high_sink_o = opt_r[4:1]; // RULE17
  assign p1_o = 8'h00;
  assign p1_oe_o = ~p1_out_i;
  assign p4_o = 4'h0;
  assign p4_oe_o = LARGE_PKG ? ~p4_r[3:0] : 4'h0; // RULE15
  assign p4_in_o = {prog_store_strobe_s, ale_s, 1'b1, p4lo_s};
  assign port1_irq_inputs_o = p1_s; // RULE13
  assign ext_irq_zero_o = p3_s[ext_bus_pkg::EXT_IRQ_ZERO_PIN]; // RULE12
  assign ext_irq_one_o = p3_s[ext_bus_pkg::EXT_IRQ_ONE_PIN];
  assign timer_zero_count_in_o = p3_s[ext_bus_pkg::T0_PIN];
  assign timer_one_count_in_o = p3_s[ext_bus_pkg::T1_PIN];

  a_onchip_stays_off: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
    accept && int_hit |=> st_r == ext_bus_pkg::BS_IDLE ##1 prog_store_strobe_b_o || opt_r[7])
    else $error("on-chip fetch went to the external bus");
  a_select_low_ext: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
    accept && !ea_s |=> st_r == ext_bus_pkg::BS_ADDR)
    else $error("fetch with select low stayed on chip");
  a_store_code_only: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE6
    !prog_store_strobe_b_o && !opt_r[7] && !$past(opt_r[7])
      |-> $past(st_r == ext_bus_pkg::BS_STROBE && is_code(kind_r)))
    else $error("store strobe outside an external code read");
  a_store_in_fetch: assert property (@(posedge clk_i) disable iff (!rst_b_i || core_rst) // RULE5
    st_r == ext_bus_pkg::BS_STROBE && is_code(kind_r) && !opt_r[7] |=> !prog_store_strobe_b_o)
    else $error("no store strobe during external code read");
  a_addr_at_latch_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE24
    $fell(ale_o) && bus_r && !opt_r[6] |-> p0_oe_o == 8'hFF && $stable(p0_o)
      ##1 p0_oe_o == 8'hFF && $stable(p0_o))
    else $error("low address not held around latch fall");
  a_high_addr_out: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
    bus_r |-> p2_o == addr_r[15:8] && p2_oe_o == 8'hFF)
    else $error("port 2 not carrying upper address");
  a_write_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i || core_rst) // RULE11
    st_r == ext_bus_pkg::BS_STROBE && kind_r == ext_bus_pkg::KIND_DATA_WR
      |=> p3_oe_o[ext_bus_pkg::WR_PIN] && !p3_o[ext_bus_pkg::WR_PIN] && p0_o == wdata_r)
    else $error("write strobe or data missing");
  a_latch_alt_pin: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE21
    $past(opt_r[6]) |-> ale_o == $past(p4_r[ext_bus_pkg::LATCH_P4_BIT]))
    else $error("latch pin not following port 4 bit 5");
  a_latch_off_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE22
    $past(opt_r[5] && !opt_r[6]) && !bus_r |-> !ale_o)
    else $error("latch pulse while disabled");
  a_opts_cleared: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE23
    core_rst |=> opt_r == ext_bus_pkg::OPT_RESET)
    else $error("option bits survive reset");
  a_idle_gates_core: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE18
    idle_r |-> !core_clk_en_o && periph_clk_en_o == !pd_r)
    else $error("idle mode clock gating wrong");
endmodule
`default_nettype wire

// ---- hw/ext_bus_pkg.sv ----
// Shared constants and types for the external memory bus pin control
// How it works
// RULE1 - Low access select forces every code fetch out to external memory.
// RULE2 - Select high and address on-chip: keep fetch address and data off the bus.
// RULE3 - On-chip program area is 4K bytes; fetches above it go external.
// RULE4 - Program and data address spaces are each 64 KB.
// RULE5 - Store strobe pulls code bytes onto port 0 for fetches and table reads.
// RULE6 - Internal program reads emit no store strobe pulse.
// RULE7 - Latch strobe lets outside logic capture the low address byte.
// RULE8 - Port 0 carries low address, then data, on the same eight lines.
// RULE9 - Port 2 outputs the upper address byte during external accesses.
// RULE10 - Reset takes effect only after reset pin high two machine cycles, oscillator running.
// RULE11 - P3.6 is the write strobe and P3.7 the read strobe for data cycles.
// RULE12 - P3.2, P3.3 feed external interrupts; P3.4, P3.5 feed timer count inputs.
// RULE13 - Port 1 pins 0 to 7 feed port 1 interrupt inputs two to nine.
// RULE14 - Latch and store strobe pins can serve as port 4 bits 5 and 6.
// RULE15 - Port 4 is bit-addressable; pins 0 to 3 exist only on larger packages.
// RULE16 - Port 0 weak pull-ups switch on only by software setting.
// RULE17 - Pins P3.4 to P3.7 each selectable as high-sink outputs.
// RULE18 - Idle mode stops the core clock, peripheral clocks keep running.
// RULE19 - Power-down mode halts the crystal oscillator.
// RULE20 - Fully static: clock may stop anywhere without corrupting state.
// RULE21 - Alternate enable bits turn latch pin into P4.5, store pin into P4.6.
// RULE22 - Latch strobe pulses until latch alternate or pulse-off bit is set.
// RULE23 - Reset clears all port option bits, restoring standard pin functions.
// RULE24 - Low address valid on port 0 before latch strobe falls, held just after.
package ext_bus_pkg;
  localparam int ADDR_W = 16;
  localparam logic [16:0] ONCHIP_ROM_BYTES = 17'h01000;
  localparam int MACHINE_CYCLE_CLKS = 12;
  localparam int RESET_HOLD_MCYCLES = 2;
  localparam int RESET_HOLD_CLKS = RESET_HOLD_MCYCLES * MACHINE_CYCLE_CLKS;
  localparam int PHASE_CLKS = 2;
  localparam int ALE_PULSE_CLKS = 2;
  localparam logic [3:0] MCYC_LAST = 4'(MACHINE_CYCLE_CLKS - 1);
  localparam logic [1:0] PHASE_LAST = 2'(PHASE_CLKS - 1);
  localparam logic [3:0] ALE_PULSE_END = 4'(ALE_PULSE_CLKS);
  localparam int WR_PIN = 6;
  localparam int RD_PIN = 7;
  localparam int EXT_IRQ_ZERO_PIN = 2;
  localparam int EXT_IRQ_ONE_PIN = 3;
  localparam int T0_PIN = 4;
  localparam int T1_PIN = 5;
  localparam int HS_LO_PIN = 4;
  localparam int LATCH_P4_BIT = 5;
  localparam int STORE_P4_BIT = 6;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [6:0] P4_RESET = 7'h7F;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  typedef enum logic [1:0] {
    KIND_FETCH,
    KIND_CODE_READ,
    KIND_DATA_RD,
    KIND_DATA_WR
  } req_kind_t;
  typedef enum {
    BS_IDLE,
    BS_ADDR,
    BS_HOLD,
    BS_STROBE,
    BS_FINISH
  } bus_state_t;
endpackage

// ---- hw/reset_link_if.sv ----
// Reset qualification link between pin control and its reset qualifier
`timescale 1ns/1ns
`default_nettype none
interface reset_link_if;
  logic core_rst;
  logic osc_run;
  modport qual (output core_rst, input osc_run);
  modport user (input core_rst, output osc_run);
endinterface
`default_nettype wire

// ---- hw/reset_qualify.sv ----
// Reset pin qualifier: reset only after a long enough high level
`timescale 1ns/1ns
`default_nettype none
module reset_qualify (
  input wire logic clk_i, // Oscillator clock
  input wire logic rst_b_i, // Async power-on reset, active low
  input wire logic reset_pin_i, // Raw reset pin, active high
  reset_link_if.qual link // Qualified reset out, oscillator state in
);
  logic pin_meta_r;
  logic pin_sync_r;
  logic [5:0] hold_cnt_r;
  logic core_rst_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= reset_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Count consecutive high clocks only while the oscillator runs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt_r <= 6'h00;
      core_rst_r <= 1'b0;
    end else if (!pin_sync_r) begin
      hold_cnt_r <= 6'h00;
      core_rst_r <= 1'b0;
    end else if (link.osc_run) begin
      if (hold_cnt_r == 6'(ext_bus_pkg::RESET_HOLD_CLKS - 1)) begin
        core_rst_r <= 1'b1; // RULE10
      end else begin
        hold_cnt_r <= hold_cnt_r + 6'h01;
      end
    end
  end

  assign link.core_rst = core_rst_r;

  a_reset_needs_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE10
    $rose(core_rst_r) |-> hold_cnt_r == 6'(ext_bus_pkg::RESET_HOLD_CLKS - 1) && $past(pin_sync_r))
    else $error("core reset rose without full hold time");
  a_reset_drops: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE10
    !pin_sync_r |=> !core_rst_r)
    else $error("core reset held after pin released");
endmodule
`default_nettype wire

// ---- dv/ext_mem_model.sv ----
// Behavioural external code and data memory behind an address latch
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  input wire logic clk_i, // Clock
  input wire logic ale_i, // Latch strobe pin level
  input wire logic [7:0] bus_i, // Port 0 wire level
  input wire logic [7:0] hi_i, // Port 2 pins
  input wire logic code_b_i, // Code read strobe, low active
  input wire logic rd_b_i, // Data read strobe, low active
  input wire logic wr_b_i, // Data write strobe, low active
  output logic [7:0] bus_o // Byte offered to port 0
);
  logic [7:0] lo_r;
  logic [7:0] last_r;
  logic [7:0] cur;
  logic [7:0] mem [256];
  logic [1:0] hold_r;
  initial begin
    hold_r = 2'h0;
    last_r = 8'h00;
    lo_r = 8'h00;
    foreach (mem[i]) mem[i] = 8'hEE;
  end
  always @(negedge ale_i) lo_r = bus_i;
  assign cur = !code_b_i ? (lo_r ^ hi_i ^ 8'h5A) : mem[lo_r ^ hi_i];
  // Data held two clocks past the strobe, then the inverse of the last byte
  always @(posedge clk_i) begin
    if (!wr_b_i) mem[lo_r ^ hi_i] <= bus_i;
    if (!code_b_i || !rd_b_i) last_r <= cur;
    if (!code_b_i || !rd_b_i) hold_r <= 2'h2;
    else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
  end
  assign bus_o = (!code_b_i || !rd_b_i) ? cur : (hold_r != 2'h0 ? last_r : ~last_r);
endmodule
`default_nettype wire

// ---- dv/ext_memory_bus_pin_control_tb.sv ----
// Self-checking bench for the external memory bus pin control
`timescale 1ns/1ns
`default_nettype none
module ext_memory_bus_pin_control_tb;
  logic clk_i, rst_b_i, reset_pin_i, ext_access_select_i, req_valid_i, req_ready_o, rsp_valid_o;
  logic rsp_internal_o, core_rst_o, port0_weak_pullup_en_i, latch_pin_alt_enable_i, opt_wr_i;
  logic store_pin_alt_enable_i, latch_pulse_off_i, p4_bit_wr_i, p4_bit_val_i, idle_req_i, wake_i;
  logic power_down_req_i, p0_pullup_o, ale_i, ale_o, ale_oe_o, prog_store_strobe_i, prog_store_strobe_b_o;
  logic prog_store_strobe_oe_o, ext_irq_zero_o, ext_irq_one_o, timer_zero_count_in_o, timer_one_count_in_o;
  logic core_clk_en_o, periph_clk_en_o, osc_en_o, hi;
  logic [1:0] req_kind_i;
  logic [2:0] p4_bit_sel_i;
  logic [3:0] high_sink_select_i, p3_high_sink_o, p4_i, p4_o, p4_oe_o;
  logic [6:0] p4_in_o;
  logic [7:0] port1_irq_inputs_o;
  logic [15:0] req_addr_i;
  logic [7:0] req_wdata_i, rom_data_i, rsp_data_o, p0_out_i, p1_out_i, p2_out_i, p3_out_i, p0_i;
  logic [7:0] p0_o, p0_oe_o, p1_i, p1_o, p1_oe_o, p2_o, p2_oe_o, p3_i, p3_o, p3_oe_o, ext_b, q;
  int err_total, samples_checked, cyc, prog_store_strobe_cnt, n;
  ext_bus_ctrl ext_bus_ctrl_inst (.*);
  ext_mem_model ext_mem_model_inst (.clk_i(clk_i), .ale_i(ale_i), .bus_i(p0_i), .hi_i(p2_o),
    .code_b_i(prog_store_strobe_b_o | ~prog_store_strobe_oe_o), .rd_b_i(~(p3_oe_o[7] & ~p3_o[7])),
    .wr_b_i(~(p3_oe_o[6] & ~p3_o[6])), .bus_o(ext_b));
  assign p0_i = (p0_oe_o & p0_o) | (~p0_oe_o & ext_b);
  assign ale_i = ale_o;
  assign prog_store_strobe_i = prog_store_strobe_b_o;
  assign p4_i = ~p4_oe_o | p4_o;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(negedge prog_store_strobe_b_o) if (prog_store_strobe_oe_o === 1'b1) prog_store_strobe_cnt++;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic req(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {req_valid_i, req_kind_i, req_addr_i, req_wdata_i, rom_data_i} = {1'b1, k, a, d, d};
    for (n = 0; n < 40 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (n = 0; n < 40 && rsp_valid_o !== 1'b1; n++) @(negedge clk_i);
    chk("rsp_valid_o", rsp_valid_o, 1'b1);
    q = rsp_data_o;
  endtask
  task automatic t_alt();
    {p1_i, p3_i} = {8'h96, 8'h28};
    wt(3);
    chk("port1_irq_inputs_o", port1_irq_inputs_o, 8'h96);
    chk("p3 alternates", {ext_irq_zero_o, ext_irq_one_o, timer_zero_count_in_o,
      timer_one_count_in_o}, 4'h5);
    p3_i = 8'hFF;
    $display("t_alt done");
  endtask
  task automatic t_code();
    int base;
    base = prog_store_strobe_cnt;
    req(2'h0, 16'h0FFF, 8'h3C);
    chk("internal data", q, 8'h3C);
    chk("internal flag", rsp_internal_o, 1'b1);
    req(2'h1, 16'h0000, 8'hC3);
    chk("no store strobe", prog_store_strobe_cnt, base);
    for (int i = 0; i < 2; i++) begin
      req(2'(i), i ? 16'hABCD : 16'h1000, 8'h00);
      chk("external code", q, (i ? 8'hCD ^ 8'hAB : 8'h00 ^ 8'h10) ^ 8'h5A);
      chk("external flag", rsp_internal_o, 1'b0);
    end
    chk("store strobes", prog_store_strobe_cnt, base + 2);
    ext_access_select_i = 1'b0;
    wt(3);
    req(2'h0, 16'h0010, 8'h00);
    chk("forced external", q, 8'h10 ^ 8'h5A);
    ext_access_select_i = 1'b1;
    $display("t_code done");
  endtask
  task automatic t_data();
    int base;
    base = prog_store_strobe_cnt;
    req(2'h3, 16'h1234, 8'hA5);
    req(2'h3, 16'hFFFF, 8'h5C);
    req(2'h2, 16'h1234, 8'h00);
    chk("data read lo", q, 8'hA5);
    req(2'h2, 16'hFFFF, 8'h00);
    chk("data read top", q, 8'h5C);
    chk("no strobe on data", prog_store_strobe_cnt, base);
    $display("t_data done");
  endtask
  task automatic t_opts();
    chk("opts after reset", {p0_pullup_o, p3_high_sink_o}, 5'h00);
    for (n = 0; n < 13 && ale_o !== 1'b1; n++) @(negedge clk_i);
    chk("idle latch pulse", n < 13, 1'b1);
    latch_pulse_off_i = 1'b1;
    pulse(opt_wr_i);
    hi = 1'b0;
    repeat (24) begin
      @(negedge clk_i);
      hi |= ale_o;
    end
    chk("latch pulse off", hi, 1'b0);
    {port0_weak_pullup_en_i, high_sink_select_i, latch_pin_alt_enable_i} = 6'h35;
    {store_pin_alt_enable_i, latch_pulse_off_i} = 2'h3;
    pulse(opt_wr_i);
    wt(2);
    chk("p0_pullup_o", p0_pullup_o, 1'b1);
    chk("p3_high_sink_o", p3_high_sink_o, 4'hA);
    for (int i = 0; i < 3; i++) begin
      {p4_bit_sel_i, p4_bit_val_i} = {i == 0 ? 3'h5 : (i == 1 ? 3'h6 : 3'h0), 1'b0};
      pulse(p4_bit_wr_i);
    end
    hi = 1'b0;
    repeat (24) begin
      @(negedge clk_i);
      hi |= ale_o;
    end
    chk("latch pin as port", {ale_oe_o, hi, prog_store_strobe_oe_o, prog_store_strobe_b_o}, 4'hA);
    chk("p4 bit 0", {p4_oe_o[0], p4_in_o[0]}, 2'h2);
    $display("t_opts done");
  endtask
  task automatic t_modes();
    pulse(idle_req_i);
    wt(2);
    chk("idle clocks", {core_clk_en_o, periph_clk_en_o, req_ready_o}, 3'h2);
    pulse(wake_i);
    pulse(power_down_req_i);
    wt(2);
    chk("osc_en_o", osc_en_o, 1'b0);
    pulse(wake_i);
    wt(2);
    chk("state kept", {osc_en_o, core_clk_en_o, p3_high_sink_o}, 6'h3A);
    $display("t_modes done");
  endtask
  task automatic t_rstpin();
    reset_pin_i = 1'b1;
    wt(20);
    chk("short reset pin", core_rst_o, 1'b0);
    reset_pin_i = 1'b0;
    wt(5);
    reset_pin_i = 1'b1;
    wt(30);
    chk("long reset pin", core_rst_o, 1'b1);
    reset_pin_i = 1'b0;
    wt(6);
    chk("options cleared", {core_rst_o, p0_pullup_o, p3_high_sink_o, p4_oe_o}, 10'h000);
    $display("t_rstpin done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_b_i, reset_pin_i, req_valid_i, req_kind_i, req_addr_i, req_wdata_i, rom_data_i} = '0;
    {port0_weak_pullup_en_i, high_sink_select_i, latch_pin_alt_enable_i, opt_wr_i} = '0;
    {store_pin_alt_enable_i, latch_pulse_off_i, p4_bit_wr_i, p4_bit_sel_i, p4_bit_val_i} = '0;
    {idle_req_i, power_down_req_i, wake_i, err_total, samples_checked, cyc, prog_store_strobe_cnt} = '0;
    {ext_access_select_i, p0_out_i, p1_out_i, p2_out_i, p3_out_i, p1_i, p3_i} = '1;
    wt(16);
    rst_b_i = 1'b1;
    wt(3);
    t_alt();
    t_code();
    t_data();
    t_opts();
    t_modes();
    t_rstpin();
    conclude();
  end
endmodule
`default_nettype wire
